// File: logic/phy_autoneg_and_mode_registers.sv
// management register bank for autoneg and chip working mode
// ==========================================================
`timescale 1ns/10ps

module phy_autoneg_and_mode_registers
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // management access, same clock domain
  input  wire mgmt_req_t  mgmt_req,
  output logic [15:0]     mgmt_rdata,
  output logic            mgmt_rvalid,
  // clause-22 shadow registers
  input  wire logic [15:0] c22_adv,
  input  wire logic [15:0] c22_partner_ability,
  input  wire logic [15:0] c22_ms_control,
  output logic            c22_adv_wr,
  output logic [15:0]     c22_adv_wdata,
  output logic            c22_ms_wr,
  output logic [15:0]     c22_ms_wdata,
  // negotiation engine
  input  wire an_status_t an_status,
  input  wire logic       next_page_taken,
  output logic            next_page_loaded_flag,
  output logic [47:0]     ext_page_tx,
  // extended control from serdes power control
  input  wire logic       serdes_down_keep,
  // chip control outputs
  output logic            serdes_space_sel,
  output logic            chip_soft_reset,
  output logic            copper_serial_bridge_reset,
  output serdes_mode_t    serdes_mode,
  output logic            rate_adapt_buffer_en,
  output logic            watchdog_bypass,
  output logic            rlb_serdes_en,
  output logic            rlb_copper_en,
  output logic            rlb_forward_en
);

  // ==========================================================
  // storage
  logic [15:0] ext_word0;
  logic [15:0] ext_word1;
  logic [15:0] ext_word2;
  logic [15:0] mgc;
  logic        role_conflict_latch;
  logic [15:0] eee_a;
  logic [15:0] eee_b;
  logic [15:0] mgcb;
  logic [15:0] space_sel;
  logic [15:0] work_mode;
  logic [15:0] addr_ctl;
  logic [15:0] sync_cfg;
  logic        soft_rst_pulse;

  wire logic wr = mgmt_req.wr;
  wire logic rd = mgmt_req.rd;
  wire logic [15:0] a = mgmt_req.addr;
  wire logic [15:0] d = mgmt_req.wdata;
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (nw & mask);
  endfunction

  // ==========================================================
  // extended next page words
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_word0 <= zero_word;
      ext_word1 <= zero_word;
      ext_word2 <= zero_word;
    end
    else if (wr)
    begin
      if (a == off_ext_page_tx_word0)
        ext_word0 <= d;
      else if (a == off_ext_page_tx_word1)
        ext_word1 <= d;
      else if (a == off_ext_page_tx_word2)
        ext_word2 <= d;
    end
  end
  assign ext_page_tx = {ext_word2, ext_word1, ext_word0};
  // load wins over the engine taking the page in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      next_page_loaded_flag <= 1'b0;
    else if (wr && a == off_ext_page_tx_word0)
      next_page_loaded_flag <= 1'b1;
    else if (next_page_taken)
      next_page_loaded_flag <= 1'b0;
  end

  // ==========================================================
  // multigig control; role bits live in clause-22 register 9
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mgc <= mgc_reset;
    else if (wr && a == off_multigig_an_control)
      mgc <= merge(mgc, d, mgc_wmask);
  end
  always_comb
  begin
    c22_ms_wr    = wr && (a == off_multigig_an_control);
    c22_ms_wdata = c22_ms_control;
    c22_ms_wdata[c22_role_en_bit -: 3] = d[role_en_bit -: 3];
    c22_adv_wr    = wr && (a == off_an_adv_mirror);
    c22_adv_wdata = d;
  end
  // event sets win over a clearing read in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      role_conflict_latch <= 1'b0;
    else if (an_status.role_fault)
      role_conflict_latch <= 1'b1;
    else if (rd && a == off_multigig_an_status)
      role_conflict_latch <= 1'b0;
  end

  // ==========================================================
  // EEE advertisement and THP request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eee_a <= zero_word;
      eee_b <= zero_word;
      mgcb  <= mgcb_reset;
    end
    else if (wr)
    begin
      if (a == off_local_eee_adv_a)
        eee_a <= merge(eee_a, d, eee_a_wmask);
      else if (a == off_local_eee_adv_b)
        eee_b <= merge(eee_b, d, eee_b_wmask);
      else if (a == off_multigig_an_control_b)
        mgcb <= merge(mgcb, d, mgcb_wmask);
    end
  end

  // ==========================================================
  // common extended registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      space_sel <= zero_word;
      work_mode <= mode_reset;
      addr_ctl  <= addr_reset;
      sync_cfg  <= zero_word;
    end
    else if (wr)
    begin
      if (a == off_register_space_select)
        space_sel <= merge(space_sel, d, sel_wmask);
      else if (a == off_chip_working_mode)
        work_mode <= merge(work_mode, d, mode_wmask);
      else if (a == off_mgmt_address_control)
        addr_ctl <= merge(addr_ctl, d, addr_wmask);
      else if (a == off_sync_loop_config)
        sync_cfg <= merge(sync_cfg, d, sync_wmask);
    end
  end
  // bit15 itself never stores zero; the write makes a single pulse
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_rst_pulse <= 1'b0;
    else
      soft_rst_pulse <= wr && a == off_chip_working_mode
                        && !d[soft_rst_bit];
  end
  assign chip_soft_reset            = soft_rst_pulse;
  assign serdes_space_sel           = space_sel[space_bit];
  assign copper_serial_bridge_reset = work_mode[bridge_rst_bit];
  assign watchdog_bypass            = addr_ctl[wdog_bypass_bit];
  assign rlb_serdes_en              = sync_cfg[rlb_serdes_bit];
  assign rlb_copper_en              = sync_cfg[rlb_copper_bit];
  assign rlb_forward_en = sync_cfg[rlb_fwd_bit]
                          && (rlb_serdes_en || rlb_copper_en);

  // ==========================================================
  // serdes mode steering
  always_comb
  begin
    serdes_mode          = serdes_off;
    rate_adapt_buffer_en = 1'b0;
    case (work_mode[2:0])
      mode_auto:
      begin
        if (an_status.link_up)
          serdes_mode = (an_status.speed == speed_2500) ?
                        serdes_2500x : serdes_sgmii;
        else
          serdes_mode = serdes_down_keep ?
                        serdes_sgmii : serdes_off;
      end
      mode_forced:
      begin
        serdes_mode = serdes_2500x;
        rate_adapt_buffer_en = !(an_status.link_up
                          && an_status.speed == speed_2500);
      end
      mode_manual:
        serdes_mode = serdes_manual;
      default:
        serdes_mode = serdes_off;
    endcase
  end

  // ==========================================================
  // read path, one cycle after the request
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = zero_word;
    if (a == off_an_adv_mirror)
      next_rdata = c22_adv;
    else if (a == off_an_partner_base_page)
      next_rdata = c22_partner_ability;
    else if (a == off_ext_page_tx_word0)
      next_rdata = ext_word0;
    else if (a == off_ext_page_tx_word1)
      next_rdata = ext_word1;
    else if (a == off_ext_page_tx_word2)
      next_rdata = ext_word2;
    else if (a == off_multigig_an_control)
    begin
      next_rdata = mgc;
      next_rdata[role_en_bit -: 3] = c22_ms_control[c22_role_en_bit -: 3];
    end
    else if (a == off_multigig_an_status)
      next_rdata = {role_conflict_latch, an_status.role_master,
                    an_status.local_rx_ok, an_status.remote_rx_ok,
                    1'b0, an_status.partner_loop_timing, 3'h0,
                    an_status.partner_5g, an_status.partner_2g5,
                    an_status.partner_fr_5g, an_status.partner_fr_2g5,
                    3'h0};
    else if (a == off_local_eee_adv_a)
      next_rdata = eee_a;
    else if (a == off_partner_eee_adv_a)
      next_rdata = {12'h000, an_status.partner_eee_ge, 1'b0};
    else if (a == off_local_eee_adv_b)
      next_rdata = eee_b;
    else if (a == off_partner_eee_adv_b)
      next_rdata = {14'h0000, an_status.partner_eee_2g5};
    else if (a == off_multigig_an_control_b)
      next_rdata = mgcb;
    else if (a == off_multigig_an_status_b)
      next_rdata = {12'h000, an_status.partner_thp_req, 3'h0};
    else if (a == off_register_space_select)
      next_rdata = space_sel;
    else if (a == off_chip_working_mode)
      next_rdata = work_mode;
    else if (a == off_mgmt_address_control)
      next_rdata = addr_ctl;
    else if (a == off_sync_loop_config)
      next_rdata = sync_cfg;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mgmt_rdata  <= zero_word;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      mgmt_rvalid <= rd;
      if (rd)
        mgmt_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // checks
  property p_fault_latch;
    @(posedge ref_clk) disable iff (!rst_n)
    an_status.role_fault |=> role_conflict_latch;
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("role fault not latched");
  property p_fault_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    rd && a == off_multigig_an_status && !an_status.role_fault
    |=> !role_conflict_latch;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("role fault not cleared on read");
  property p_page_loaded;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && a == off_ext_page_tx_word0 |=> next_page_loaded_flag;
  endproperty
  a_page_loaded: assert property (p_page_loaded)
    else $error("page loaded flag not set");
  sequence s_reset_write;
    wr && a == off_chip_working_mode && !d[soft_rst_bit];
  endsequence
  property p_soft_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    s_reset_write |=> chip_soft_reset ##1 (work_mode[soft_rst_bit]);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset pulse wrong");
  property p_auto_buffer;
    @(posedge ref_clk) disable iff (!rst_n)
    work_mode[2:0] == mode_auto |-> !rate_adapt_buffer_en;
  endproperty
  a_auto_buffer: assert property (p_auto_buffer)
    else $error("buffer active in auto mode");
  property p_forced;
    @(posedge ref_clk) disable iff (!rst_n)
    work_mode[2:0] == mode_forced |-> serdes_mode == serdes_2500x
      && rate_adapt_buffer_en == !(an_status.link_up
         && an_status.speed == speed_2500);
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced mode output wrong");
  property p_space_sel;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && a == off_register_space_select |=>
      serdes_space_sel == $past(d[space_bit]);
  endproperty
  a_space_sel: assert property (p_space_sel)
    else $error("space select not stored");
  property p_forward;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && a == off_sync_loop_config && d[rlb_fwd_bit]
      && (d[rlb_serdes_bit] || d[rlb_copper_bit]) |=> rlb_forward_en;
  endproperty
  a_forward: assert property (p_forward)
    else $error("forwarding not enabled with loopback");

endmodule // phy_autoneg_and_mode_registers

// File: pkg/phy_regs_pkg.sv
// register map, fields and types for the autoneg and mode register bank
package phy_regs_pkg;

  // ==========================================================
  // offsets: autoneg device space
  localparam logic [15:0] off_an_adv_mirror         = 16'h0010;
  localparam logic [15:0] off_an_partner_base_page  = 16'h0013;
  localparam logic [15:0] off_ext_page_tx_word0     = 16'h0016;
  localparam logic [15:0] off_ext_page_tx_word1     = 16'h0017;
  localparam logic [15:0] off_ext_page_tx_word2     = 16'h0018;
  localparam logic [15:0] off_multigig_an_control   = 16'h0020;
  localparam logic [15:0] off_multigig_an_status    = 16'h0021;
  localparam logic [15:0] off_local_eee_adv_a       = 16'h003c;
  localparam logic [15:0] off_partner_eee_adv_a     = 16'h003d;
  localparam logic [15:0] off_local_eee_adv_b       = 16'h003e;
  localparam logic [15:0] off_partner_eee_adv_b     = 16'h003f;
  localparam logic [15:0] off_multigig_an_control_b = 16'h0040;
  localparam logic [15:0] off_multigig_an_status_b  = 16'h0041;

  // ==========================================================
  // offsets: common extended space
  localparam logic [15:0] off_register_space_select = 16'ha000;
  localparam logic [15:0] off_chip_working_mode     = 16'ha001;
  localparam logic [15:0] off_mgmt_address_control  = 16'ha005;
  localparam logic [15:0] off_sync_loop_config      = 16'ha006;

  // ==========================================================
  // writable masks and reset values
  localparam logic [15:0] mgc_wmask  = 16'hf1e1;
  localparam logic [15:0] mgc_reset  = 16'h0081;
  localparam logic [15:0] eee_a_wmask = 16'h007e;
  localparam logic [15:0] eee_b_wmask = 16'h0003;
  localparam logic [15:0] mgcb_wmask = 16'h000c;
  localparam logic [15:0] mgcb_reset = 16'h000c;
  localparam logic [15:0] sel_wmask  = 16'h0002;
  localparam logic [15:0] mode_wmask = 16'h7807;
  localparam logic [15:0] mode_reset = 16'h8000;
  localparam logic [15:0] addr_wmask = 16'h04ff;
  localparam logic [15:0] addr_reset = 16'h00c0;
  localparam logic [15:0] sync_wmask = 16'hfef0;
  localparam logic [15:0] zero_word  = 16'h0000;

  // ==========================================================
  // field positions
  localparam int role_en_bit     = 15;
  localparam int role_val_bit    = 14;
  localparam int multiport_bit   = 13;
  localparam int c22_role_en_bit = 12;
  localparam int fault_bit       = 15;
  localparam int space_bit       = 1;
  localparam int soft_rst_bit    = 15;
  localparam int bridge_rst_bit  = 14;
  localparam int serdes_pd_bit   = 13;
  localparam int wdog_bypass_bit = 10;
  localparam int rlb_serdes_bit  = 6;
  localparam int rlb_copper_bit  = 5;
  localparam int rlb_fwd_bit     = 4;

  localparam logic [2:0] mode_auto   = 3'h0;
  localparam logic [2:0] mode_forced = 3'h1;
  localparam logic [2:0] mode_manual = 3'h5;

  typedef enum logic [1:0] {
    speed_10, speed_100, speed_1000, speed_2500
  } copper_speed_t;

  typedef enum logic [1:0] {
    serdes_off, serdes_sgmii, serdes_2500x, serdes_manual
  } serdes_mode_t;

  // ==========================================================
  // status from the negotiation engine
  typedef struct packed {
    logic          role_fault;
    logic          role_master;
    logic          local_rx_ok;
    logic          remote_rx_ok;
    logic          partner_loop_timing;
    logic          partner_5g;
    logic          partner_2g5;
    logic          partner_fr_5g;
    logic          partner_fr_2g5;
    logic [2:0]    partner_eee_ge;
    logic [1:0]    partner_eee_2g5;
    logic          partner_thp_req;
    logic          link_up;
    copper_speed_t speed;
  } an_status_t;

  // management access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage

// File: verif/c22_shadow_model.sv
// clause-22 shadow register model facing the register bank
`timescale 1ns/10ps

module c22_shadow_model
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // write strobes from the bank
  input  wire logic        c22_adv_wr,
  input  wire logic [15:0] c22_adv_wdata,
  input  wire logic        c22_ms_wr,
  input  wire logic [15:0] c22_ms_wdata,
  // shadow values
  output logic [15:0]      c22_adv,
  output logic [15:0]      c22_ms_control
);

  // ==========================================================
  // strobes last one cycle, so they are taken on the edge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      c22_adv <= 16'h0000;
    else if (c22_adv_wr)
      c22_adv <= c22_adv_wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      c22_ms_control <= 16'h0000;
    else if (c22_ms_wr)
      c22_ms_control <= c22_ms_wdata;
  end

endmodule // c22_shadow_model

// File: verif/tb.sv
// self-checking bench for the autoneg and mode register bank
`timescale 1ns/10ps

`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("[FAIL] %s exp %h got %h", nm, ex, got); \
    end \
  end

module tb;
  import phy_regs_pkg::*;

  // ==========================================================
  // signals
  logic          ref_clk;
  logic          rst_n;
  mgmt_req_t     req;
  logic [15:0]   rdata;
  logic          rvalid;
  logic [15:0]   c22_adv;
  logic [15:0]   c22_pa;
  logic [15:0]   c22_ms;
  logic          adv_wr;
  logic [15:0]   adv_wd;
  logic          ms_wr;
  logic [15:0]   ms_wd;
  an_status_t    st;
  logic          np_taken;
  logic          np_flag;
  logic [47:0]   xnp;
  logic          keep;
  logic          space_sel;
  logic          soft_rst;
  logic          bridge_rst;
  serdes_mode_t  smode;
  logic          buf_en;
  logic          wdog;
  logic          rlb_s;
  logic          rlb_c;
  logic          rlb_f;
  int            errors;
  int            comparisons;

  phy_autoneg_and_mode_registers i_phy_autoneg_and_mode_registers (
    .ref_clk(ref_clk), .rst_n(rst_n), .mgmt_req(req),
    .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
    .c22_adv(c22_adv), .c22_partner_ability(c22_pa),
    .c22_ms_control(c22_ms), .c22_adv_wr(adv_wr),
    .c22_adv_wdata(adv_wd), .c22_ms_wr(ms_wr), .c22_ms_wdata(ms_wd),
    .an_status(st), .next_page_taken(np_taken),
    .next_page_loaded_flag(np_flag), .ext_page_tx(xnp),
    .serdes_down_keep(keep), .serdes_space_sel(space_sel),
    .chip_soft_reset(soft_rst), .copper_serial_bridge_reset(bridge_rst),
    .serdes_mode(smode), .rate_adapt_buffer_en(buf_en),
    .watchdog_bypass(wdog), .rlb_serdes_en(rlb_s),
    .rlb_copper_en(rlb_c), .rlb_forward_en(rlb_f));

  c22_shadow_model i_c22_shadow_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .c22_adv_wr(adv_wr),
    .c22_adv_wdata(adv_wd), .c22_ms_wr(ms_wr), .c22_ms_wdata(ms_wd),
    .c22_adv(c22_adv), .c22_ms_control(c22_ms));

  // ==========================================================
  // management access
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge ref_clk);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] ex,
                    input string nm);
    @(posedge ref_clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge ref_clk);
    #1;
    req.rd = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK(nm, ex, rdata)
  endtask

  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(16'h0020, 16'h0081, "rst_mgc");
    rd(16'h0040, 16'h000c, "rst_mgcb");
    rd(16'ha001, 16'h8000, "rst_mode");
    rd(16'ha005, 16'h00c0, "rst_addr");
    rd(16'ha006, 16'h0000, "rst_sync");
    rd(16'h003c, 16'h0000, "rst_eee");
  endtask

  task automatic t_mirror;
    c22_pa = 16'h5a3c;
    wr(off_an_adv_mirror, 16'h1de1);
    `CHK("c22_adv", 16'h1de1, c22_adv)
    rd(off_an_adv_mirror, 16'h1de1, "adv");
    wr(off_an_partner_base_page, 16'hffff);
    rd(off_an_partner_base_page, 16'h5a3c, "lp_base");
  endtask

  task automatic t_page;
    wr(off_ext_page_tx_word1, 16'hbbbb);
    wr(off_ext_page_tx_word2, 16'hcccc);
    `CHK("np_flag0", 1'b0, np_flag)
    wr(off_ext_page_tx_word0, 16'haaaa);
    `CHK("np_flag1", 1'b1, np_flag)
    `CHK("xnp", 48'hccccbbbbaaaa, xnp)
    np_taken = 1'b1;
    @(posedge ref_clk);
    #1;
    np_taken = 1'b0;
    `CHK("np_flag2", 1'b0, np_flag)
  endtask

  task automatic t_role;
    wr(off_multigig_an_control, 16'hffff);
    `CHK("c22_ms", 16'h1c00, c22_ms)
    rd(off_multigig_an_control, 16'hf1e1, "mgc");
    wr(off_multigig_an_control, 16'h4000);
    `CHK("c22_ms2", 16'h0800, c22_ms)
    rd(off_multigig_an_control, 16'h4000, "mgc2");
  endtask

  task automatic t_status;
    st.role_master = 1'b1;
    st.local_rx_ok = 1'b1;
    st.partner_loop_timing = 1'b1;
    st.partner_2g5 = 1'b1;
    st.partner_fr_5g = 1'b1;
    st.role_fault = 1'b1;
    @(posedge ref_clk);
    #1;
    st.role_fault = 1'b0;
    rd(off_multigig_an_status, 16'he430, "mgs1");
    rd(off_multigig_an_status, 16'h6430, "mgs2");
    st = '0;
    st.remote_rx_ok = 1'b1;
    st.partner_5g = 1'b1;
    st.partner_fr_2g5 = 1'b1;
    rd(off_multigig_an_status, 16'h1048, "mgs3");
  endtask

  task automatic t_eee;
    st.partner_eee_ge = 3'h5;
    st.partner_eee_2g5 = 2'h1;
    st.partner_thp_req = 1'b1;
    wr(off_local_eee_adv_a, 16'hffff);
    rd(off_local_eee_adv_a, 16'h007e, "eee_a");
    wr(off_local_eee_adv_b, 16'hffff);
    rd(off_local_eee_adv_b, 16'h0003, "eee_b");
    wr(off_partner_eee_adv_a, 16'hffff);
    rd(off_partner_eee_adv_a, 16'h000a, "lp_eee_a");
    rd(off_partner_eee_adv_b, 16'h0001, "lp_eee_b");
    wr(off_multigig_an_control_b, 16'h0000);
    rd(off_multigig_an_control_b, 16'h0000, "mgcb");
    rd(off_multigig_an_status_b, 16'h0008, "mgsb");
  endtask

  task automatic t_space;
    wr(off_register_space_select, 16'hffff);
    `CHK("space_sel", 1'b1, space_sel)
    rd(off_register_space_select, 16'h0002, "space");
    wr(off_register_space_select, 16'h0000);
    `CHK("space_sel0", 1'b0, space_sel)
  endtask

  task automatic t_soft;
    wr(off_chip_working_mode, 16'h4001);
    `CHK("soft_rst", 1'b1, soft_rst)
    @(posedge ref_clk);
    #1;
    `CHK("soft_rst_end", 1'b0, soft_rst)
    `CHK("bridge_rst", 1'b1, bridge_rst)
    rd(off_chip_working_mode, 16'hc001, "mode");
    wr(off_chip_working_mode, 16'h8000);
    `CHK("soft_rst_no", 1'b0, soft_rst)
    `CHK("bridge_rst0", 1'b0, bridge_rst)
  endtask

  task automatic chk_mode(input logic [2:0] m, input logic up,
                          input copper_speed_t sp, input logic k,
                          input serdes_mode_t em, input logic eb);
    st.link_up = up;
    st.speed = sp;
    keep = k;
    wr(off_chip_working_mode, {13'h1000, m});
    `CHK("serdes_mode", em, smode)
    if (m != mode_manual)
      `CHK("buf_en", eb, buf_en)
  endtask

  task automatic t_modes;
    chk_mode(mode_auto, 1'b1, speed_2500, 1'b0, serdes_2500x, 1'b0);
    chk_mode(mode_auto, 1'b1, speed_1000, 1'b0, serdes_sgmii, 1'b0);
    chk_mode(mode_auto, 1'b1, speed_10, 1'b0, serdes_sgmii, 1'b0);
    chk_mode(mode_auto, 1'b0, speed_10, 1'b1, serdes_sgmii, 1'b0);
    chk_mode(mode_auto, 1'b0, speed_10, 1'b0, serdes_off, 1'b0);
    chk_mode(mode_forced, 1'b1, speed_2500, 1'b0, serdes_2500x, 1'b0);
    chk_mode(mode_forced, 1'b1, speed_100, 1'b0, serdes_2500x, 1'b1);
    chk_mode(mode_manual, 1'b1, speed_100, 1'b0, serdes_manual, 1'b0);
    chk_mode(3'h2, 1'b1, speed_2500, 1'b0, serdes_off, 1'b0);
  endtask

  task automatic t_misc;
    wr(off_mgmt_address_control, 16'h0400);
    `CHK("wdog", 1'b1, wdog)
    rd(off_mgmt_address_control, 16'h0400, "addr_ctl");
    wr(off_sync_loop_config, 16'h0070);
    `CHK("rlb_s", 1'b1, rlb_s)
    `CHK("rlb_c", 1'b1, rlb_c)
    `CHK("rlb_f", 1'b1, rlb_f)
    wr(off_sync_loop_config, 16'h0010);
    `CHK("rlb_f_off", 1'b0, rlb_f)
    wr(off_sync_loop_config, 16'h0030);
    `CHK("rlb_f_cu", 1'b1, rlb_f)
    wr(off_sync_loop_config, 16'hffff);
    rd(off_sync_loop_config, 16'hfef0, "sync");
    wr(16'h1234, 16'hffff);
    rd(16'h1234, 16'h0000, "unmapped");
  endtask

  // mid-run reset brings stored state back to its reset values
  task automatic t_rerun;
    wr(off_ext_page_tx_word0, 16'h1111);
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    `CHK("rerun_flag", 1'b0, np_flag)
    `CHK("rerun_rlb", 1'b0, rlb_s)
    rd(off_chip_working_mode, mode_reset, "rerun_mode");
    rd(off_multigig_an_control, mgc_reset, "rerun_mgc");
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(25 * 4000);
    errors++;
    results;
  end

  initial
  begin
    req = '0;
    st = '0;
    c22_pa = 16'h0000;
    np_taken = 1'b0;
    keep = 1'b0;
    rst_n = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_mirror;
    t_page;
    t_role;
    t_status;
    t_eee;
    t_space;
    t_soft;
    t_modes;
    t_misc;
    t_rerun;
    results;
  end

endmodule // tb
